// ---- design/phy_ext_pkg.sv ----
// Package with register map, field layout and reset values of the extended register bank
package phy_ext_pkg;
  // Register indices of the five registers; the bus byte address is four times the index
  localparam logic [7:0] ADDR_MAC_TERM = 8'h13;
  localparam logic [7:0] ADDR_PS_DS = 8'h14;
  localparam logic [7:0] ADDR_EE_CTRL = 8'h15;
  localparam logic [7:0] ADDR_EE_DATA = 8'h16;
  localparam logic [7:0] ADDR_IP_CRC = 8'h17;
  // Field positions
  localparam int TERM_LSB = 14;
  localparam int SLEEP_LSB = 13;
  localparam int LSTO_LSB = 9;
  localparam int RXCLK_OFF_BIT = 5;
  localparam int DS_EN_BIT = 4;
  localparam int DS_CNT_LSB = 2;
  localparam int DS_STAT_BIT = 1;
  localparam int EE_RELOAD_BIT = 14;
  localparam int EE_GO_BIT = 13;
  localparam int EE_DIR_BIT = 12;
  localparam int EE_RDY_BIT = 11;
  localparam int RDATA_LSB = 8;
  localparam int PHYAD_LSB = 11;
  localparam int IP_EN_BIT = 10;
  localparam int IP_STAT_LSB = 8;
  // Reset values
  localparam logic [1:0] SLEEP_RST = 2'h1;
  localparam logic [1:0] LSTO_RST = 2'h1;
  localparam logic [1:0] DS_CNT_RST = 2'h1;
  localparam logic EE_DIR_RST = 1'b1;
  localparam logic [10:0] EE_ADDR_RST = 11'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] CRC_MAX = 8'hff;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Configuration strap bundle
  typedef struct packed {
    logic [1:0] term;
    logic ds_en;
    logic [4:0] phy_addr;
  } strap_t;

  // EEPROM engine request toward the external serial port
  typedef struct packed {
    logic start;
    logic read;
    logic [10:0] addr;
    logic [7:0] wdata;
  } ee_req_t;

  // EEPROM engine completion from the external serial port
  typedef struct packed {
    logic done;
    logic [7:0] rdata;
  } ee_rsp_t;

  // Control settings handed to the PHY core
  typedef struct packed {
    logic [1:0] term_sel;
    logic [1:0] sleep_sel;
    logic [1:0] lsto_sel;
    logic rx_clk_off;
    logic ds_en;
    logic [1:0] ds_count;
    logic ee_reload;
    logic ip_det_en;
  } ctrl_t;
endpackage : phy_ext_pkg

// ---- design/phy_ext_ctrl_eeprom_regs.sv ----
// Extended register bank: termination, power save, downshift, EEPROM engine, inline power, CRC
// Summary of operation
// - Two-bit sticky termination select, reset from strap pins, picks 50/60/30/45 ohm.
// - Sticky sleep timer field 14:13 selects one to four seconds, reset 01.
// - Field 10:9 selects link status time-out one to four seconds, reset 01.
// - Bit 5 set holds the receive clock to the MAC low; resets 0.
// - Sticky bit 4 enables gigabit speed downshift; reset from strap pins.
// - Sticky bits 3:2 pick two to five failed attempts before downshift.
// - Read-only bit 1 shows downshift needed or done; resets 0.
// - Bit 14 requests EEPROM reload after soft reset; survives soft reset.
// - Writing 1 to bit 13 launches one EEPROM access; self-clears after.
// - Read-only bit 11 reads 1 when the EEPROM engine is ready.
// - Byte fetched by a read access appears in read-only bits 15:8.
// - Bits 7:0 hold the byte written on a write access; reset 00.
// - Bits 15:11 show the five-bit PHY address latched at reset.
// - Sticky bit 10 of control-4 enables inline power detection.
// - Bits 9:8 report detection: searching, needs power, no power needed.
// - Eight-bit CRC error counter saturates at ff and clears when read.
`timescale 1ns/1ps
module phy_ext_ctrl_eeprom_regs
  import phy_ext_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset,
  input wire strap_t config_strap_pins,
  input wire logic rx_clk_in,
  output logic rx_clk_out,
  input wire logic downshift_event,
  input wire logic [1:0] inline_power_status,
  input wire logic crc_error,
  output ctrl_t ctrl,
  output ee_req_t ee_req,
  input wire ee_rsp_t ee_rsp,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // EEPROM engine states
  typedef enum logic [1:0] {
    EE_IDLE = 2'b01,
    EE_BUSY = 2'b10
  } ee_state_t;

  // Address decode shared by both bus directions
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[31:10] == 22'h0) && (a[1:0] == 2'b00) &&
      ((a[9:2] == ADDR_MAC_TERM) || (a[9:2] == ADDR_PS_DS) || (a[9:2] == ADDR_EE_CTRL) ||
       (a[9:2] == ADDR_EE_DATA) || (a[9:2] == ADDR_IP_CRC));
  endfunction : addr_hit

  // Pin input synchronisers
  logic [1:0] ds_sync_reg;
  logic [1:0] ip_s1_reg;
  logic [1:0] ip_s2_reg;
  logic [2:0] crc_sync_reg;
  strap_t strap_s1_reg;
  strap_t strap_s2_reg;

  // Register fields
  logic [1:0] term_reg;
  logic [1:0] sleep_reg;
  logic [1:0] lsto_reg;
  logic rxclk_off_reg;
  logic ds_en_reg;
  logic [1:0] ds_cnt_reg;
  logic ds_stat_reg;
  logic ee_reload_reg;
  logic ee_dir_reg;
  logic [10:0] ee_addr_reg;
  logic [7:0] ee_rdata_reg;
  logic [7:0] ee_wdata_reg;
  logic [4:0] phy_addr_reg;
  logic ip_en_reg;
  logic [1:0] ip_stat_reg;
  logic [7:0] crc_cnt_reg;
  logic strap_pending_reg;
  ee_state_t ee_state_reg;
  logic ee_start_reg;

  // Bus channel state
  logic aw_held_reg;
  logic w_held_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rd_word;
  logic [15:0] wd;
  logic lo_en;
  logic hi_en;
  logic crc_inc;

  // Strap synchronisers run through reset so the straps are settled at release
  always_ff @(posedge aclk) begin
    strap_s1_reg <= config_strap_pins;
    strap_s2_reg <= strap_s1_reg;
  end

  // Two-flop synchronisers for pin-level inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ds_sync_reg <= 2'h0;
      ip_s1_reg <= 2'h0;
      ip_s2_reg <= 2'h0;
      crc_sync_reg <= 3'h0;
    end else begin
      ds_sync_reg <= {ds_sync_reg[0], downshift_event};
      ip_s1_reg <= inline_power_status;
      ip_s2_reg <= ip_s1_reg;
      crc_sync_reg <= {crc_sync_reg[1:0], crc_error};
    end
  end

  // Write acceptance: address and data taken independently, response after both
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wd = w_data_reg[15:0];
  assign lo_en = w_strb_reg[0];
  assign hi_en = w_strb_reg[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 32'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_hit(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_word = 32'h0;
    case (s_axi_araddr[9:2])
      ADDR_MAC_TERM: rd_word[15:0] = {term_reg, 14'h0};
      ADDR_PS_DS: rd_word[15:0] = {1'b0, sleep_reg, 2'b00, lsto_reg, 3'b000, rxclk_off_reg,
                                   ds_en_reg, ds_cnt_reg, ds_stat_reg, 1'b0};
      ADDR_EE_CTRL: rd_word[15:0] = {1'b0, ee_reload_reg, ee_state_reg == EE_BUSY, ee_dir_reg,
                                     ee_state_reg == EE_IDLE, ee_addr_reg};
      ADDR_EE_DATA: rd_word[15:0] = {ee_rdata_reg, ee_wdata_reg};
      ADDR_IP_CRC: rd_word[15:0] = {phy_addr_reg, ip_en_reg, ip_stat_reg, crc_cnt_reg};
      default: rd_word = 32'h0;
    endcase
    if (!addr_hit(s_axi_araddr)) begin
      rd_word = 32'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sticky and non-sticky control fields; strap values load one cycle after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_pending_reg <= 1'b1;
      term_reg <= 2'h0;
      sleep_reg <= SLEEP_RST;
      lsto_reg <= LSTO_RST;
      rxclk_off_reg <= 1'b0;
      ds_en_reg <= 1'b0;
      ds_cnt_reg <= DS_CNT_RST;
      ip_en_reg <= 1'b0;
      ee_reload_reg <= 1'b0;
      ee_dir_reg <= EE_DIR_RST;
      ee_addr_reg <= EE_ADDR_RST;
      ee_wdata_reg <= BYTE_RST;
      phy_addr_reg <= 5'h00;
    end else if (strap_pending_reg) begin
      strap_pending_reg <= 1'b0;
      term_reg <= strap_s2_reg.term;
      ds_en_reg <= strap_s2_reg.ds_en;
      phy_addr_reg <= strap_s2_reg.phy_addr;
    end else begin
      if (soft_reset) begin
        // Non-sticky fields return to default; sticky and super-sticky keep their value
        lsto_reg <= LSTO_RST;
        rxclk_off_reg <= 1'b0;
        ee_dir_reg <= EE_DIR_RST;
        ee_addr_reg <= EE_ADDR_RST;
        ee_wdata_reg <= BYTE_RST;
      end else if (wr_fire && addr_hit(aw_addr_reg)) begin
        case (aw_addr_reg[9:2])
          ADDR_MAC_TERM: if (hi_en) term_reg <= wd[TERM_LSB +: 2];
          ADDR_PS_DS: begin
            if (hi_en) sleep_reg <= wd[SLEEP_LSB +: 2];
            if (hi_en) lsto_reg <= {wd[LSTO_LSB + 1], wd[LSTO_LSB]};
            if (lo_en) rxclk_off_reg <= wd[RXCLK_OFF_BIT];
            if (lo_en) ds_en_reg <= wd[DS_EN_BIT];
            if (lo_en) ds_cnt_reg <= wd[DS_CNT_LSB +: 2];
          end
          ADDR_EE_CTRL: begin
            if (hi_en) ee_reload_reg <= wd[EE_RELOAD_BIT];
            if (hi_en) ee_dir_reg <= wd[EE_DIR_BIT];
            if (hi_en) ee_addr_reg[10:8] <= wd[10:8];
            if (lo_en) ee_addr_reg[7:0] <= wd[7:0];
          end
          ADDR_EE_DATA: if (lo_en) ee_wdata_reg <= wd[7:0];
          ADDR_IP_CRC: if (hi_en) ip_en_reg <= wd[IP_EN_BIT];
          default: ;
        endcase
      end
    end
  end

  // EEPROM access engine: launch on a write of 1 to go while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ee_state_reg <= EE_IDLE;
      ee_start_reg <= 1'b0;
      ee_rdata_reg <= BYTE_RST;
    end else begin
      ee_start_reg <= 1'b0;
      case (ee_state_reg)
        EE_IDLE: begin
          if (wr_fire && addr_hit(aw_addr_reg) && aw_addr_reg[9:2] == ADDR_EE_CTRL && hi_en
              && wd[EE_GO_BIT]
              && !soft_reset && !strap_pending_reg) begin
            ee_state_reg <= EE_BUSY;
            ee_start_reg <= 1'b1;
          end
        end
        EE_BUSY: begin
          if (ee_rsp.done) begin
            ee_state_reg <= EE_IDLE;
            if (ee_dir_reg) ee_rdata_reg <= ee_rsp.rdata;
          end
        end
        default: ee_state_reg <= EE_IDLE;
      endcase
    end
  end

  // Downshift status, inline power status and saturating CRC error counter
  assign crc_inc = crc_sync_reg[1] && !crc_sync_reg[2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ds_stat_reg <= 1'b0;
      ip_stat_reg <= 2'h0;
      crc_cnt_reg <= 8'h00;
    end else begin
      ds_stat_reg <= ds_en_reg && ds_sync_reg[1];
      ip_stat_reg <= ip_en_reg ? ip_s2_reg : 2'h0;
      if (rd_fire && s_axi_araddr[9:2] == ADDR_IP_CRC && addr_hit(s_axi_araddr)) begin
        crc_cnt_reg <= {7'h00, crc_inc};
      end else if (crc_inc && crc_cnt_reg != CRC_MAX) begin
        crc_cnt_reg <= crc_cnt_reg + 8'h01;
      end
    end
  end

  // Receive clock gate toward the MAC
  assign rx_clk_out = rx_clk_in & !rxclk_off_reg;

  // Settings and EEPROM request to the rest of the PHY
  assign ctrl = '{term_sel: term_reg, sleep_sel: sleep_reg, lsto_sel: lsto_reg,
                  rx_clk_off: rxclk_off_reg, ds_en: ds_en_reg, ds_count: ds_cnt_reg,
                  ee_reload: ee_reload_reg, ip_det_en: ip_en_reg};
  assign ee_req = '{start: ee_start_reg, read: ee_dir_reg, addr: ee_addr_reg,
                    wdata: ee_wdata_reg};

endmodule : phy_ext_ctrl_eeprom_regs

// ---- tb/phy_ext_regs_sva.sv ----
// Checker for the extended register bank, bound to its ports
`timescale 1ns/1ps
module phy_ext_regs_chk
  import phy_ext_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset,
  input wire strap_t config_strap_pins,
  input wire logic rx_clk_in,
  input wire logic rx_clk_out,
  input wire ctrl_t ctrl,
  input wire ee_req_t ee_req,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Clock gate, launch pulse and bus answers
  property p_rxclk_gate; rx_clk_out == (rx_clk_in && !ctrl.rx_clk_off); endproperty
  property p_go_pulse; ee_req.start |=> !ee_req.start; endproperty
  property p_go_cause;
    ee_req.start |-> $rose(s_axi_bvalid) && $past(s_axi_wdata[EE_GO_BIT], 2);
  endproperty
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  // Defaults after reset and strap capture
  property p_rst_dflt;
    $rose(aresetn) |-> ctrl.sleep_sel == SLEEP_RST && ctrl.lsto_sel == LSTO_RST
      && ctrl.ds_count == DS_CNT_RST && !ctrl.rx_clk_off && !ctrl.ee_reload && !ctrl.ip_det_en
      && ee_req.read == EE_DIR_RST && ee_req.addr == EE_ADDR_RST && !ee_req.start;
  endproperty
  property p_strap;
    $rose(aresetn) |=> ctrl.term_sel == config_strap_pins.term
      && ctrl.ds_en == config_strap_pins.ds_en;
  endproperty
  // Software reset keeps sticky fields and returns time-out, clock gate and EEPROM direction to default
  property p_soft_keep;
    soft_reset && !s_axi_wvalid && !$rose(aresetn) |=> $stable(ctrl.term_sel)
      && $stable(ctrl.sleep_sel) && $stable(ctrl.ds_count) && $stable(ctrl.ds_en)
      && $stable(ctrl.ee_reload) && $stable(ctrl.ip_det_en);
  endproperty
  property p_soft_clr;
    soft_reset && !s_axi_wvalid && !$rose(aresetn) |=> ctrl.lsto_sel == LSTO_RST
      && !ctrl.rx_clk_off
      && ee_req.read == EE_DIR_RST;
  endproperty
  a_rxclk_gate: assert property (p_rxclk_gate) else $error("receive clock gate wrong");
  a_go_pulse: assert property (p_go_pulse) else $error("launch pulse too long");
  a_go_cause: assert property (p_go_cause) else $error("launch without write");
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  a_b_drop: assert property (p_b_drop) else $error("write response held");
  a_rst_dflt: assert property (p_rst_dflt) else $error("reset defaults wrong");
  a_strap: assert property (p_strap) else $error("strap values not taken");
  a_soft_keep: assert property (p_soft_keep) else $error("sticky field lost");
  a_soft_clr: assert property (p_soft_clr) else $error("soft reset not applied");
  c_go: cover property (ee_req.start);
  c_soft: cover property (soft_reset);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : phy_ext_regs_chk

bind phy_ext_ctrl_eeprom_regs phy_ext_regs_chk i_phy_ext_regs_chk (.aclk, .aresetn, .soft_reset,
  .config_strap_pins, .rx_clk_in, .rx_clk_out, .ctrl, .ee_req, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ---- tb/tb.sv ----
// Self-checking testbench for the extended register bank
`timescale 1ns/1ps
module tb
  import phy_ext_pkg::*;
;
  localparam logic [7:0] A_TERM = ADDR_MAC_TERM << 2;
  localparam logic [7:0] A_PSDS = ADDR_PS_DS << 2;
  localparam logic [7:0] A_EEC = ADDR_EE_CTRL << 2;
  localparam logic [7:0] A_EED = ADDR_EE_DATA << 2;
  localparam logic [7:0] A_IPC = ADDR_IP_CRC << 2;
  logic aclk = 0, aresetn = 0, soft_reset = 0, rx_clk_in = 0, downshift_event = 0, crc_error = 0;
  strap_t config_strap_pins = '0;
  logic [1:0] inline_power_status = 2'h0;
  ee_rsp_t ee_rsp = '0;
  ctrl_t ctrl;
  ee_req_t ee_req;
  logic rx_clk_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, v, ph;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [41:0] q[$];
  logic [41:0] e;
  logic [10:0] ea;
  logic [7:0] rb, wb;
  int n_mismatch = 0, checked = 0;

  phy_ext_ctrl_eeprom_regs i_phy_ext_ctrl_eeprom_regs (.aclk, .aresetn, .soft_reset,
    .config_strap_pins, .rx_clk_in, .rx_clk_out, .downshift_event, .inline_power_status,
    .crc_error, .ctrl, .ee_req, .ee_rsp, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // Clock and a random receive clock from the core
  always #4 aclk = ~aclk;
  always @(posedge aclk) rx_clk_in <= 1'($urandom);

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (x !== g) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // Response monitor: takes the oldest note at every completed handshake
  always @(negedge aclk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      e = q.pop_front();
      chk($sformatf("resp_%h", e[41:34]), 32'(e[33:32]),
        32'(s_axi_rvalid ? s_axi_rresp : s_axi_bresp));
      if (s_axi_rvalid) chk($sformatf("rdata_%h", e[41:34]), e[31:0], s_axi_rdata);
    end
  end

  task automatic waitf(ref logic f);
    logic t;
    do begin
      @(negedge aclk);
      t = f;
      @(posedge aclk);
    end while (!t);
  endtask : waitf

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic ta, tw, da, dw;
    da = 0;
    dw = 0;
    q.push_back({a, r, 32'h0});
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    waitf(s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    q.push_back({a, r, d});
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    waitf(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    waitf(s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // One completion from the serial port, rdata scrambled outside it
  task ee_done(input logic [7:0] b);
    ee_rsp <= {1'b1, b};
    @(posedge aclk);
    ee_rsp <= {1'b0, ~b};
    @(posedge aclk);
  endtask : ee_done

  task crc(input int n);
    repeat (n) begin
      crc_error <= 1'b1;
      @(posedge aclk);
      crc_error <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask : crc

  task conclude();
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    conclude();
  end

  initial begin
    void'($urandom(32'h99be));
    config_strap_pins = strap_t'(8'($urandom));
    ea = 11'($urandom);
    rb = 8'($urandom);
    wb = 8'($urandom);
    ph = 32'(config_strap_pins.phy_addr) << 11;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset values, then unmapped and misaligned places
    rd(A_TERM, 32'(config_strap_pins.term) << 14);
    rd(A_PSDS, 32'h2204 | (32'(config_strap_pins.ds_en) << 4));
    rd(A_EEC, 32'h1800);
    rd(A_EED, 32'h0);
    rd(A_IPC, ph);
    rd(8'h60, 32'h0, RESP_SLVERR);
    rd(A_TERM + 8'h1, 32'h0, RESP_SLVERR);
    wr(8'h60, 32'hffff, RESP_SLVERR);
    // Every code of the termination, power-save and downshift fields, reserved bits random in the power-save and downshift writes
    for (int i = 0; i < 4; i++) begin
      wr(A_TERM, 32'(i) << 14);
      chk("term_sel", 32'(i), 32'(ctrl.term_sel));
      v = (32'(i) << 13) | (32'(i) << 9) | (32'(i) << 2) | (32'(i & 1) << 5) | (32'(i >> 1) << 4);
      wr(A_PSDS, v | ($urandom & 32'hffff99c3));
      rd(A_PSDS, v);
    end
    downshift_event <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(A_PSDS, v | 32'h2);
    downshift_event <= 1'b0;
    // EEPROM read then write access
    wr(A_EEC, 32'h3000 | 32'(ea));
    chk("ee_req", 32'({1'b1, ea, 8'h0}), 32'({ee_req.read, ee_req.addr, ee_req.wdata}));
    rd(A_EEC, 32'h3000 | 32'(ea));
    ee_done(rb);
    rd(A_EEC, 32'h1800 | 32'(ea));
    rd(A_EED, 32'(rb) << 8);
    wr(A_EED, 32'(wb));
    wr(A_EEC, 32'h2000 | 32'(ea));
    chk("ee_req", 32'({1'b0, ea, wb}), 32'({ee_req.read, ee_req.addr, ee_req.wdata}));
    ee_done(~rb);
    rd(A_EED, {16'h0, rb, wb});
    rd(A_EEC, 32'h0800 | 32'(ea));
    // Software reset with reload requested
    wr(A_EEC, 32'h4000);
    soft_reset <= 1'b1;
    @(posedge aclk);
    soft_reset <= 1'b0;
    rd(A_PSDS, 32'h621c);
    rd(A_EEC, 32'h5800);
    // Detection result hidden while disabled
    inline_power_status <= 2'h1;
    repeat (4) @(posedge aclk);
    rd(A_IPC, ph);
    for (int j = 1; j < 3; j++) begin
      inline_power_status <= 2'(j);
      wr(A_IPC, 32'h400);
      rd(A_IPC, ph | 32'h400 | (32'(j) << 8));
    end
    // Error counter counts, saturates and clears on read
    crc(5);
    rd(A_IPC, ph | 32'h605);
    crc(300);
    rd(A_IPC, ph | 32'h6ff);
    rd(A_IPC, ph | 32'h600);
    conclude();
  end
endmodule : tb
